/* File: hw/pxb_pkg.sv */
package pxb_pkg;
  // Pin counts: ports 0..3 reach the crossbar, port 4 is plain GPIO.
  localparam int XB_PINS = 32;
  localparam int IO_PINS = 40;
  localparam int HI_W = IO_PINS - XB_PINS;
  // Crossbar slots in descending priority, the fixed serial pins last.
  localparam int SLOTS = 25;
  localparam int SLOT_W = 5;
  localparam int XB_SLOTS = 23;
  localparam int SLOT_SPI = 0;
  localparam int SPI_PINS = 4;
  localparam int SLOT_TWB0 = 4;
  localparam int SLOT_CP0 = 6;
  localparam int SLOT_CP0A = 7;
  localparam int SLOT_CP1 = 8;
  localparam int SLOT_CP1A = 9;
  localparam int SLOT_CLK = 10;
  localparam int SLOT_CEX = 11;
  localparam int CEX_MAX = 5;
  localparam int SLOT_ECI = 16;
  localparam int SLOT_T0 = 17;
  localparam int SLOT_T1 = 18;
  localparam int SLOT_SER1 = 19;
  localparam int SLOT_TWB1 = 21;
  localparam int SLOT_SER0_TX = 23;
  localparam int SLOT_SER0_RX = 24;
  localparam int SER0_TX_PIN = 4;
  localparam int SER0_RX_PIN = 5;
  // Field positions of the three crossbar route enable registers.
  localparam int R0_SER0 = 0;
  localparam int R0_SPI = 1;
  localparam int R0_TWB0 = 2;
  localparam int R0_CLK = 3;
  localparam int R0_CP0 = 4;
  localparam int R0_CP0A = 5;
  localparam int R0_CP1 = 6;
  localparam int R0_CP1A = 7;
  localparam int R1_CEX_LSB = 0;
  localparam int R1_CEX_W = 3;
  localparam int R1_ECI = 3;
  localparam int R1_T0 = 4;
  localparam int R1_T1 = 5;
  localparam int R1_CROSSBAR_MASTER_ENABLE = 6;
  localparam int R2_SER1 = 0;
  localparam int R2_TWB1 = 1;
  localparam int R2_W = 2;
  // External interrupt pin configuration and timer control fields.
  localparam int IRQ_SEL_W = 3;
  localparam int IRQ_A_SEL = 0;
  localparam int IRQ_A_POL = 3;
  localparam int IRQ_B_SEL = 4;
  localparam int IRQ_B_POL = 7;
  localparam int TC_A_TYPE = 0;
  localparam int TC_A_PEND = 1;
  localparam int TC_B_TYPE = 2;
  localparam int TC_B_PEND = 3;
  // Register byte addresses on the APB port.
  localparam logic [7:0] A_ROUTE0 = 8'h00;
  localparam logic [7:0] A_ROUTE1 = 8'h04;
  localparam logic [7:0] A_ROUTE2 = 8'h08;
  localparam logic [7:0] A_IRQCFG = 8'h0c;
  localparam logic [7:0] A_TCTL = 8'h10;
  localparam logic [7:0] A_PORT_LO = 8'h14;
  localparam logic [7:0] A_PORT_HI = 8'h18;
  localparam logic [7:0] A_LATCH_LO = 8'h1c;
  localparam logic [7:0] A_LATCH_HI = 8'h20;
  localparam logic [7:0] A_SKIP = 8'h24;
  localparam logic [7:0] A_MDIN_LO = 8'h28;
  localparam logic [7:0] A_MDIN_HI = 8'h2c;
  localparam logic [7:0] A_MDOUT_LO = 8'h30;
  localparam logic [7:0] A_MDOUT_HI = 8'h34;
  // Reset values.
  localparam logic [IO_PINS-1:0] RST_LATCH = 40'hff_ffff_ffff;
  localparam logic [IO_PINS-1:0] RST_MDIN = 40'hff_ffff_ffff;
endpackage

/* File: hw/pxb_irq_sense.sv */
module pxb_irq_sense (
  input wire logic core_clk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic sampleIn, // Filtered level of the selected pin.
  input wire logic edgeMode, // Trigger type: 1 edge, 0 level.
  input wire logic activeHigh, // Polarity: 1 rising/high, 0 falling/low.
  input wire logic vectorAck, // Processor vectors to the service routine.
  output logic pending // Interrupt pending flag.
);
  import pxb_pkg::*;

  typedef struct packed {
    logic prevAct;
    logic pend;
  } pxb_irq_t;

  pxb_irq_t st_reg;
  pxb_irq_t st_next;
  logic actNow;
  logic edgeHit;

  // Active level per polarity, and its leading edge.
  assign actNow = (sampleIn == activeHigh);
  assign edgeHit = actNow & ~st_reg.prevAct;

  // Edge mode latches and is cleared on vectoring; a new edge wins.
  always_comb
  begin
    st_next = st_reg;
    st_next.prevAct = actNow;
    if (edgeMode)
    begin
      st_next.pend = edgeHit | (st_reg.pend & ~vectorAck);
    end
    else
    begin
      st_next.pend = actNow;
    end
  end

  // The previous level starts active so reset makes no false edge.
  always_ff @(posedge core_clk)
  begin
    if (srst)
      st_reg <= '{prevAct: 1'b1, pend: 1'b0};
    else
      st_reg <= st_next;
  end

  assign pending = st_reg.pend;

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence edgeSeen;
    edgeMode && actNow && !st_reg.prevAct;
  endsequence

  edge_sets_a: assert property (edgeSeen |=> pending)
    else $error("Selected edge did not set pending.");
  ack_clears_a: assert property (edgeMode && vectorAck && !edgeHit |=> !pending)
    else $error("Vectoring did not clear edge pending.");
  edge_holds_a: assert property (edgeMode && pending && !vectorAck |=> pending)
    else $error("Edge pending lost without vectoring.");
  level_follow_a: assert property (!edgeMode |=> pending == $past(actNow))
    else $error("Level pending does not follow input.");
endmodule

/* File: hw/pxb_port_ctrl.sv */
module pxb_port_ctrl (
  input wire logic core_clk, // System clock, 25 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic [pxb_pkg::IO_PINS-1:0] pinIn, // Pin input levels.
  output logic [pxb_pkg::IO_PINS-1:0] pinOut, // Pin output values.
  output logic [pxb_pkg::IO_PINS-1:0] pinOe, // Pin output enables.
  input wire logic [pxb_pkg::SLOTS-1:0] periphOut, // Peripheral output per slot.
  input wire logic [pxb_pkg::SLOTS-1:0] periphDrive, // Peripheral drive request per slot.
  output logic [pxb_pkg::SLOTS-1:0] periphIn, // Pin level seen by each slot.
  input wire logic vectorAckA, // Processor vectors to interrupt A.
  input wire logic vectorAckB, // Processor vectors to interrupt B.
  output logic extIrqAPending, // Interrupt A pending.
  output logic extIrqBPending // Interrupt B pending.
);
  import pxb_pkg::*;

  typedef struct packed {
    logic [IO_PINS-1:0] sync1, sync2, sync3, filt;
    logic [IO_PINS-1:0] latch, mdin, mdout, pinOut, pinOe;
    logic [XB_PINS-1:0] skip;
    logic [7:0] route0, route1, irqCfg;
    logic [R2_W-1:0] route2;
    logic [1:0] trigType;
    logic [SLOTS-1:0] periphIn;
    logic [31:0] prdata;
    logic pready, pslverr;
  } pxb_state_t;

  // The synchroniser starts at the pulled-up idle level, so no false level request follows reset.
  localparam pxb_state_t ST_RST = '{sync1: '1, sync2: '1, sync3: '1, filt: '1,
                                    latch: RST_LATCH, mdin: RST_MDIN, default: '0};

  pxb_state_t st_reg;
  pxb_state_t st_next;
  logic irqSampleA;
  logic irqSampleB;
  logic pendA;
  logic pendB;

  // Interrupt inputs tap port 0 whatever the crossbar does with the pin.
  assign irqSampleA = st_reg.filt[st_reg.irqCfg[IRQ_A_SEL +: IRQ_SEL_W]];
  assign irqSampleB = st_reg.filt[st_reg.irqCfg[IRQ_B_SEL +: IRQ_SEL_W]];

  // Two identical sensing channels; the source keeps a level request up.
  pxb_irq_sense irqA (
    .core_clk(core_clk),
    .srst(srst),
    .sampleIn(irqSampleA),
    .edgeMode(st_reg.trigType[0]),
    .activeHigh(st_reg.irqCfg[IRQ_A_POL]),
    .vectorAck(vectorAckA),
    .pending(pendA)
  );

  pxb_irq_sense irqB (
    .core_clk(core_clk),
    .srst(srst),
    .sampleIn(irqSampleB),
    .edgeMode(st_reg.trigType[1]),
    .activeHigh(st_reg.irqCfg[IRQ_B_POL]),
    .vectorAck(vectorAckB),
    .pending(pendB)
  );

  // Synchroniser, crossbar placement, pin drive and the APB slave.
  always_comb
  begin
    logic [XB_PINS-1:0] taken;
    logic [XB_PINS-1:0] own;
    logic [XB_PINS-1:0][SLOT_W-1:0] slotOf;
    logic [SLOTS-1:0] slotEn;
    logic [IO_PINS-1:0] val;
    logic [IO_PINS-1:0] drv;
    logic [IO_PINS-1:0] agree;
    logic [31:0] rd;
    logic found;
    logic hit;
    logic xbarEn;
    logic setupAcc;
    logic doneAcc;
    taken = '0;
    own = '0;
    slotOf = '0;
    slotEn = '0;
    val = '0;
    drv = '0;
    agree = '0;
    rd = '0;
    found = 1'b0;
    hit = 1'b0;
    xbarEn = st_reg.route1[R1_CROSSBAR_MASTER_ENABLE];
    setupAcc = psel & penable & ~st_reg.pready;
    doneAcc = psel & penable & st_reg.pready;
    st_next = st_reg;

    // A pin change counts once the second and third stages agree.
    st_next.sync1 = pinIn;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    agree = ~(st_reg.sync2 ^ st_reg.sync3);
    st_next.filt = (agree & st_reg.sync3) | (~agree & st_reg.filt);

    // Slot enables, listed from highest to lowest priority.
    for (int k = 0; k < SPI_PINS; k++)
      slotEn[SLOT_SPI + k] = st_reg.route0[R0_SPI];
    slotEn[SLOT_TWB0] = st_reg.route0[R0_TWB0];
    slotEn[SLOT_TWB0 + 1] = st_reg.route0[R0_TWB0];
    slotEn[SLOT_CP0] = st_reg.route0[R0_CP0];
    slotEn[SLOT_CP0A] = st_reg.route0[R0_CP0A];
    slotEn[SLOT_CP1] = st_reg.route0[R0_CP1];
    slotEn[SLOT_CP1A] = st_reg.route0[R0_CP1A];
    slotEn[SLOT_CLK] = st_reg.route0[R0_CLK];
    for (int k = 0; k < CEX_MAX; k++)
      slotEn[SLOT_CEX + k] = (st_reg.route1[R1_CEX_LSB +: R1_CEX_W] > R1_CEX_W'(k));
    slotEn[SLOT_ECI] = st_reg.route1[R1_ECI];
    slotEn[SLOT_T0] = st_reg.route1[R1_T0];
    slotEn[SLOT_T1] = st_reg.route1[R1_T1];
    slotEn[SLOT_SER1] = st_reg.route2[R2_SER1];
    slotEn[SLOT_SER1 + 1] = st_reg.route2[R2_SER1];
    slotEn[SLOT_TWB1] = st_reg.route2[R2_TWB1];
    slotEn[SLOT_TWB1 + 1] = st_reg.route2[R2_TWB1];

    // Skipped pins count as taken; the first serial port is fixed.
    taken = st_reg.skip;
    if (st_reg.route0[R0_SER0])
    begin
      own[SER0_TX_PIN] = 1'b1;
      own[SER0_RX_PIN] = 1'b1;
      slotOf[SER0_TX_PIN] = SLOT_W'(SLOT_SER0_TX);
      slotOf[SER0_RX_PIN] = SLOT_W'(SLOT_SER0_RX);
      taken[SER0_TX_PIN] = 1'b1;
      taken[SER0_RX_PIN] = 1'b1;
    end

    // Each enabled slot in turn takes the lowest pin still free.
    for (int s = 0; s < XB_SLOTS; s++)
    begin
      found = 1'b0;
      for (int i = 0; i < XB_PINS; i++)
      begin
        if (slotEn[s] && !found && !taken[i])
        begin
          found = 1'b1;
          taken[i] = 1'b1;
          own[i] = 1'b1;
          slotOf[i] = SLOT_W'(s);
        end
      end
    end

    // Owned pins follow their peripheral, the rest follow the latch.
    val = st_reg.latch;
    drv = '1;
    st_next.periphIn = '0;
    for (int i = 0; i < XB_PINS; i++)
    begin
      if (xbarEn && own[i])
      begin
        val[i] = periphOut[slotOf[i]];
        drv[i] = periphDrive[slotOf[i]];
        st_next.periphIn[slotOf[i]] = st_reg.filt[i];
      end
    end
    // Open-drain drives only a low; analog pins never drive.
    st_next.pinOut = val;
    st_next.pinOe = {IO_PINS{xbarEn}} & st_reg.mdin & drv
                  & (st_reg.mdout | ~val);

    // Read decode; port reads show pins, latch reads feed modify cycles.
    case (paddr)
      A_ROUTE0: rd = {24'h00_0000, st_reg.route0};
      A_ROUTE1: rd = {24'h00_0000, st_reg.route1};
      A_ROUTE2: rd = {30'h0000_0000, st_reg.route2};
      A_IRQCFG: rd = {24'h00_0000, st_reg.irqCfg};
      A_TCTL:
      begin
        rd[TC_A_TYPE] = st_reg.trigType[0];
        rd[TC_A_PEND] = pendA;
        rd[TC_B_TYPE] = st_reg.trigType[1];
        rd[TC_B_PEND] = pendB;
      end
      A_PORT_LO: rd = st_reg.filt[XB_PINS-1:0] & st_reg.mdin[XB_PINS-1:0];
      A_PORT_HI: rd = {24'h00_0000, st_reg.filt[IO_PINS-1:XB_PINS]
                       & st_reg.mdin[IO_PINS-1:XB_PINS]};
      A_LATCH_LO: rd = st_reg.latch[XB_PINS-1:0];
      A_LATCH_HI: rd = {24'h00_0000, st_reg.latch[IO_PINS-1:XB_PINS]};
      A_SKIP: rd = st_reg.skip;
      A_MDIN_LO: rd = st_reg.mdin[XB_PINS-1:0];
      A_MDIN_HI: rd = {24'h00_0000, st_reg.mdin[IO_PINS-1:XB_PINS]};
      A_MDOUT_LO: rd = st_reg.mdout[XB_PINS-1:0];
      A_MDOUT_HI: rd = {24'h00_0000, st_reg.mdout[IO_PINS-1:XB_PINS]};
      default: rd = '0;
    endcase
    hit = (paddr <= A_MDOUT_HI) && (paddr[1:0] == 2'b00);

    // One wait state: answer is prepared, then taken on the ready edge.
    st_next.pready = setupAcc;
    if (setupAcc)
    begin
      st_next.prdata = pwrite ? 32'h0000_0000 : rd;
      st_next.pslverr = ~hit;
    end

    // Writes take effect on the edge where ready is sampled high.
    if (doneAcc && pwrite)
    begin
      case (paddr)
        A_ROUTE0: st_next.route0 = pwdata[7:0];
        A_ROUTE1: st_next.route1 = pwdata[7:0];
        A_ROUTE2: st_next.route2 = pwdata[R2_W-1:0];
        A_IRQCFG: st_next.irqCfg = pwdata[7:0];
        A_TCTL:
        begin
          st_next.trigType[0] = pwdata[TC_A_TYPE];
          st_next.trigType[1] = pwdata[TC_B_TYPE];
        end
        A_PORT_LO, A_LATCH_LO: st_next.latch[XB_PINS-1:0] = pwdata;
        A_PORT_HI, A_LATCH_HI: st_next.latch[IO_PINS-1:XB_PINS] = pwdata[HI_W-1:0];
        A_SKIP: st_next.skip = pwdata;
        A_MDIN_LO: st_next.mdin[XB_PINS-1:0] = pwdata;
        A_MDIN_HI: st_next.mdin[IO_PINS-1:XB_PINS] = pwdata[HI_W-1:0];
        A_MDOUT_LO: st_next.mdout[XB_PINS-1:0] = pwdata;
        A_MDOUT_HI: st_next.mdout[IO_PINS-1:XB_PINS] = pwdata[HI_W-1:0];
        default: st_next.skip = st_reg.skip;
      endcase
    end
  end

  // All state registers except those of the two interrupt channels in one place.
  always_ff @(posedge core_clk)
  begin
    if (srst)
      st_reg <= ST_RST;
    else
      st_reg <= st_next;
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign pinOut = st_reg.pinOut;
  assign pinOe = st_reg.pinOe;
  assign periphIn = st_reg.periphIn;
  assign extIrqAPending = pendA;
  assign extIrqBPending = pendB;

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence readStart(logic [7:0] a);
    psel && penable && !pready && !pwrite && paddr == a;
  endsequence

  sequence writeDone(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence

  xbar_off_a: assert property (!st_reg.route1[R1_CROSSBAR_MASTER_ENABLE] |=> pinOe == '0)
    else $error("Pin driven while crossbar disabled.");
  ser0_tx_pin_a: assert property (st_reg.route0[R0_SER0] && st_reg.route1[R1_CROSSBAR_MASTER_ENABLE]
                   |=> pinOut[SER0_TX_PIN] == $past(periphOut[SLOT_SER0_TX]))
    else $error("First serial port not on its fixed pin.");
  latch_write_a: assert property (writeDone(A_LATCH_LO)
                   |=> st_reg.latch[XB_PINS-1:0] == $past(pwdata))
    else $error("Latch write not stored.");
  latch_read_a: assert property (readStart(A_LATCH_LO) ##1 pready
                   |-> prdata == st_reg.latch[XB_PINS-1:0])
    else $error("Latch read does not return the latch.");
  analog_zero_a: assert property (readStart(A_PORT_LO) ##1 pready
                   |-> (prdata & ~st_reg.mdin[XB_PINS-1:0]) == '0)
    else $error("Analog pin read back nonzero.");
  pin_read_a: assert property (readStart(A_PORT_LO) ##1 pready
                   |-> prdata == $past(st_reg.filt[XB_PINS-1:0] & st_reg.mdin[XB_PINS-1:0]))
    else $error("Port read does not show pin levels.");
  apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("Ready not a single cycle after one wait.");
  skip_first_a: assert property (st_reg.skip[0]
                   |=> pinOut[0] == $past(st_reg.latch[0]))
    else $error("Skipped pin was assigned.");
endmodule

/* File: dv/pxb_pin_model.sv */
// Circuits outside the chip that load the port pins.
module pxb_pin_model (
  input wire logic [39:0] pinOut, // Values the block drives.
  input wire logic [39:0] pinOe, // Drive enables of the block.
  input wire logic [39:0] extEn, // Outside source drives the pin.
  input wire logic [39:0] extVal, // Level of the outside source.
  output logic [39:0] pinLvl // Resolved pad level.
);
  timeunit 1ns;
  timeprecision 1ps;
  // The block wins, then an outside source; a weak pull-up holds released pads high.
  always_comb
  begin
    for (int i = 0; i < 40; i++)
    begin
      pinLvl[i] = pinOe[i] ? pinOut[i] : (extEn[i] ? extVal[i] : 1'b1);
    end
  end
endmodule

/* File: dv/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pxb_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  logic [39:0] pinIn, pinOut, pinOe, extEn = 40'h0, extVal = 40'h0;
  logic [24:0] periphOut = 25'h0, periphDrive = 25'h0ff_ffff, periphIn; // Receive slot only listens.
  logic vectorAckA = 1'b0, vectorAckB = 1'b0, extIrqAPending, extIrqBPending;
  int mismatches = 0;
  int cmpCount = 0;
  pxb_port_ctrl i_pxb_port_ctrl (.core_clk(core_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .periphOut(periphOut), .periphDrive(periphDrive), .periphIn(periphIn),
    .vectorAckA(vectorAckA), .vectorAckB(vectorAckB), .extIrqAPending(extIrqAPending),
    .extIrqBPending(extIrqBPending));
  pxb_pin_model i_pxb_pin_model (.pinOut(pinOut), .pinOe(pinOe), .extEn(extEn),
    .extVal(extVal), .pinLvl(pinIn));
  // The clock toggles every half period of 20 ns.
  always #20 core_clk = ~core_clk;
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Compares one result and reports a difference at once.
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    cmpCount++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer: setup, then access held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
    if (n >= 20)
      chk("pready", 40'h1, 40'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rdreg(input logic [7:0] a);
    apb(1'b0, a, 32'h0, rd, err);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Processor vectors to both interrupts for one cycle.
  task automatic ack_both();
    vectorAckA <= 1'b1;
    vectorAckB <= 1'b1;
    @(posedge core_clk);
    vectorAckA <= 1'b0;
    vectorAckB <= 1'b0;
    wait_cyc(3);
  endtask
  // Reset state, register defaults and an unmapped access.
  task automatic t_reset();
    chk("oe after reset", 40'h0, pinOe);
    rdreg(A_LATCH_LO);
    chk("latch reset", 40'hffff_ffff, {8'h0, rd});
    chk("pending after reset", 40'h0, {38'h0, extIrqBPending, extIrqAPending});
    apb(1'b0, 8'h38, 32'h0, rd, err);
    chk("unmapped err", 40'h1, {39'h0, err});
    chk("unmapped data", 40'h0, {8'h0, rd});
  endtask
  // First serial port on fixed pins, sync serial around a skipped pin.
  task automatic t_route();
    periphOut <= 25'h080_000d;
    wr(A_MDOUT_LO, 32'hffff_ffff);
    wr(A_SKIP, 32'h0000_0008);
    wr(A_LATCH_LO, 32'h0);
    wr(A_ROUTE0, 32'h0000_0003);
    wr(A_ROUTE1, 32'h0000_0040);
    wait_cyc(6);
    chk("routed out", 40'h55, {32'h0, pinOut[7:0] & 8'hdf});
    chk("routed oe", 40'hdf, {32'h0, pinOe[7:0] & 8'hdf});
    chk("slot3 in", 40'h1, {39'h0, periphIn[3]});
    rdreg(A_PORT_LO);
    chk("pin read", 40'h55, {8'h0, rd & 32'hffff_ffdf});
    rdreg(A_LATCH_LO);
    chk("latch read", 40'h0, {8'h0, rd});
    wr(A_PORT_LO, 32'hffff_ffff);
    wait_cyc(3);
    chk("owned kept", 40'hdd, {32'h0, pinOut[7:0] & 8'hdf});
    wr(A_LATCH_LO, 32'h0);
  endtask
  // Lower priority functions, a skipped first pin, then the master enable cleared.
  task automatic t_prio();
    periphOut <= 25'h000_0410;
    wr(A_SKIP, 32'h0000_0001);
    wr(A_ROUTE0, 32'h0000_000c);
    wait_cyc(6);
    chk("prio out", 40'h0a, {35'h0, pinOut[4:0]});
    periphOut <= 25'h055_0940;
    wr(A_ROUTE0, 32'h0000_00f0);
    wr(A_ROUTE1, 32'h0000_007a);
    wr(A_ROUTE2, 32'h0000_0003);
    wait_cyc(3);
    chk("full map", 40'h2aaa, {25'h0, pinOut[14:0]});
    wr(A_ROUTE1, 32'h0);
    wait_cyc(3);
    chk("oe off", 40'h0, pinOe);
  endtask
  // One trigger mode of interrupt A on pin 2; B stays rising edge on the receive pin 5.
  task automatic t_irq(input logic typ, input logic pol);
    wr(A_IRQCFG, {24'h0, 1'b1, 3'd5, pol, 3'd2});
    wr(A_TCTL, {29'h0, 1'b1, 1'b0, typ});
    extVal[2] <= ~pol;
    wait_cyc(8);
    ack_both();
    chk("idle pending", 40'h0, {39'h0, extIrqAPending});
    extVal[2] <= pol;
    wait_cyc(8);
    chk("active pending", 40'h1, {39'h0, extIrqAPending});
    extVal[2] <= ~pol;
    wait_cyc(8);
    chk("released pending", {39'h0, typ}, {39'h0, extIrqAPending});
    ack_both();
    chk("acked pending", 40'h0, {39'h0, extIrqAPending});
  endtask
  // All four modes, pin B on its own, an analog pin read back.
  task automatic t_irq_all();
    wr(A_MDOUT_LO, 32'h0);
    wr(A_LATCH_LO, 32'hffff_ffff);
    wr(A_ROUTE0, 32'h0000_0001);
    wr(A_ROUTE1, 32'h0000_0040);
    extEn <= 40'h24;
    for (int m = 0; m < 4; m++)
      t_irq(m[1], m[0]);
    extVal[5] <= 1'b1;
    wait_cyc(8);
    chk("b pending", 40'h1, {39'h0, extIrqBPending});
    chk("rx in", 40'h1, {39'h0, periphIn[SLOT_SER0_RX]});
    chk("a quiet", 40'h0, {39'h0, extIrqAPending});
    wr(A_MDIN_LO, 32'hffff_ff7f);
    wait_cyc(6);
    rdreg(A_PORT_LO);
    chk("analog read", 40'h40, {32'h0, rd[7:6], 6'h0});
  endtask
  // Main sequence.
  initial
  begin
    wait_cyc(2);
    srst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_route();
    t_prio();
    t_irq_all();
    finish_test();
  end
  // Watchdog against a hang.
  initial
  begin
    #200000;
    mismatches++;
    finish_test();
  end
endmodule
